// *** design/tw_pkg.sv ***
`default_nettype none

package tw_pkg;

  // bus geometry
  localparam int          ADR_W      = 8;
  localparam int          DAT_W      = 32;
  localparam int          CNT_W      = 16;
  localparam int          NUM_CH     = 2;
  localparam int          CH_A       = 0;
  localparam int          CH_B       = 1;

  // register byte offsets, one aligned word each
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_COUNT  = 8'h04;
  localparam logic [7:0]  OFS_CMP_A  = 8'h08;
  localparam logic [7:0]  OFS_CMP_B  = 8'h0C;
  localparam logic [7:0]  OFS_CEIL   = 8'h10;
  localparam logic [7:0]  OFS_FLAGS  = 8'h14;
  localparam logic [7:0]  OFS_STATUS = 8'h18;

  // counter extremes and fixed ceilings
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_ONE    = 16'h0001;
  localparam logic [15:0] TOP_8BIT   = 16'h00FF;
  localparam logic [15:0] TOP_9BIT   = 16'h01FF;
  localparam logic [15:0] TOP_10BIT  = 16'h03FF;

  // waveform modes handled by this block; others count as plain mode
  typedef enum logic [3:0] {
    MODE_NORMAL    = 4'h0,
    MODE_CTC_CMP   = 4'h4,
    MODE_FPWM_8    = 4'h5,
    MODE_FPWM_9    = 4'h6,
    MODE_FPWM_10   = 4'h7,
    MODE_CTC_CEIL  = 4'hC,
    MODE_FPWM_CEIL = 4'hE,
    MODE_FPWM_CMP  = 4'hF
  } tw_mode_e;

  // output action codes
  typedef enum logic [1:0] {
    ACT_NONE   = 2'h0,
    ACT_TOGGLE = 2'h1,
    ACT_CLEAR  = 2'h2,
    ACT_SET    = 2'h3
  } tw_action_e;

  // prescaler select codes and divide-minus-one values
  localparam logic [2:0]  CLK_STOP   = 3'h0;
  localparam logic [2:0]  CLK_DIV1   = 3'h1;
  localparam logic [2:0]  CLK_DIV8   = 3'h2;
  localparam logic [2:0]  CLK_DIV64  = 3'h3;
  localparam logic [2:0]  CLK_DIV256 = 3'h4;
  localparam logic [2:0]  CLK_DIV1K  = 3'h5;
  localparam logic [9:0]  PRE_LAST1    = 10'h000;
  localparam logic [9:0]  PRE_LAST8    = 10'h007;
  localparam logic [9:0]  PRE_LAST64   = 10'h03F;
  localparam logic [9:0]  PRE_LAST256  = 10'h0FF;
  localparam logic [9:0]  PRE_LAST1024 = 10'h3FF;

  // control word layout, bit 0 upward: mode, act_a, act_b, clk_sel, pin_dir
  typedef struct packed {
    logic [1:0] pin_dir;
    logic [2:0] clk_sel;
    logic [1:0] act_b;
    logic [1:0] act_a;
    logic [3:0] mode;
  } tw_ctrl_s;
  localparam int          CTRL_W     = 13;
  localparam logic [12:0] CTRL_RESET = 13'h0000;

  // sticky flag bit positions
  localparam int          FLAG_W     = 4;
  localparam int          FLAG_OVF   = 0;
  localparam int          FLAG_CMP_A = 1;
  localparam int          FLAG_CMP_B = 2;
  localparam int          FLAG_CAP   = 3;

endpackage

`default_nettype wire

// *** design/tw_timer16.sv ***
// Overview of operation
// - plain mode counts up only and rolls from all ones to zero
// - plain mode sets overflow flag on the tick the count becomes zero
// - clear-on-match mode clears count at compare A (4) or ceiling (12)
// - clear-on-match ceiling unbuffered; passed ceiling runs to max and wraps
// - clear-on-match action 1 toggles channel A output on each match
// - clear-on-match mode still flags overflow on max to zero
// - fast pwm modes count single-slope zero to ceiling, then restart
// - fast pwm ceilings: 0xFF, 0x1FF, 0x3FF, capture, compare A
// - fast pwm action 2 is non-inverted, action 3 inverted
// - non-inverted clears on match, sets at wrap; inverted the opposite
// - fast pwm flags overflow at ceiling, plus register flag of ceiling
// - fixed ceilings mask compare bits above the width on every write
// - capture ceiling acts at once; passed value runs to max first
// - fast pwm compare writes buffered, copied at ceiling with the clear
// - compare zero gives a one tick spike; compare at ceiling stays level
// - mode 15 action 1 toggles channel A at each match, square wave
// - fast pwm period is prescale times ceiling plus one clocks
// - output action never alters the counting sequence
// - wave reaches its pin only while the direction bit selects output
// - counter compared with each compare value continuously on equality
// - action 0 leaves the channel output unchanged in every mode
//
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module tw_timer16
  import tw_pkg::*;
(
  input  wire logic              ref_clk_in,
  input  wire logic              reset_in,
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  input  wire logic              wb_we_in,
  input  wire logic [ADR_W-1:0]  wb_adr_in,
  input  wire logic [3:0]        wb_sel_in,
  input  wire logic [DAT_W-1:0]  wb_dat_in,
  output var  logic [DAT_W-1:0]  wb_dat_out,
  output var  logic              wb_ack_out,
  output var  logic [NUM_CH-1:0] wave_pin_out,
  output var  logic [NUM_CH-1:0] wave_pin_oe_n_out
);

  // byte-lane merge of a 16-bit value with the low two bus lanes
  function automatic logic [15:0] merge16(input logic [15:0] old_val,
                                          input logic [31:0] wdat,
                                          input logic [3:0]  sel);
    logic [15:0] res;
    res = old_val;
    if (sel[0])
    begin
      res[7:0] = wdat[7:0];
    end
    if (sel[1])
    begin
      res[15:8] = wdat[15:8];
    end
    return res;
  endfunction

  tw_ctrl_s               ctrl_reg;
  logic [CNT_W-1:0]       count_reg;
  logic [CNT_W-1:0]       ceil_reg;
  logic [CNT_W-1:0]       cmp_reg [NUM_CH];
  logic [CNT_W-1:0]       buf_reg [NUM_CH];
  logic [NUM_CH-1:0]      wave_reg;
  logic [FLAG_W-1:0]      flag_reg;
  logic [FLAG_W-1:0]      flag_set;
  logic [FLAG_W-1:0]      flag_clr;
  logic                   block_reg;
  logic [9:0]             pre_cnt_reg;
  logic [9:0]             pre_last;
  logic                   tick;
  logic                   ack_reg;
  logic [DAT_W-1:0]       dat_reg;
  logic [DAT_W-1:0]       rd_data;
  logic [NUM_CH-1:0]      pin_reg;
  logic [NUM_CH-1:0]      oe_n_reg;
  logic                   req;
  logic                   wr;
  logic [ADR_W-1:0]       adr;
  logic                   is_pwm;
  logic                   is_ctc;
  logic                   top_from_cmp_a;
  logic                   top_from_ceil;
  logic [CNT_W-1:0]       top_val;
  logic [CNT_W-1:0]       width_mask;
  logic                   top_hit;
  logic                   wrap_max;
  logic [CNT_W-1:0]       count_next;
  logic [NUM_CH-1:0]      match;
  logic [NUM_CH-1:0]      cmp_wr;
  logic [CNT_W-1:0]       cmp_wdata [NUM_CH];

  // bus request decode; answer one clock after the request is seen
  assign req = wb_cyc_in & wb_stb_in & ~ack_reg;
  assign wr  = req & wb_we_in;
  assign adr = {wb_adr_in[ADR_W-1:2], 2'h0};

  // prescaler divide select
  always_comb
  begin
    case (ctrl_reg.clk_sel)
      CLK_DIV8:   pre_last = PRE_LAST8;
      CLK_DIV64:  pre_last = PRE_LAST64;
      CLK_DIV256: pre_last = PRE_LAST256;
      CLK_DIV1K:  pre_last = PRE_LAST1024;
      default:    pre_last = PRE_LAST1;
    endcase
  end

  // prescaler; the timer tick is one ref clock wide every N clocks
  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pre_cnt_reg <= PRE_LAST1;
    end
    else if (ctrl_reg.clk_sel == CLK_STOP || pre_cnt_reg == pre_last)
    begin
      pre_cnt_reg <= PRE_LAST1;
    end
    else
    begin
      pre_cnt_reg <= pre_cnt_reg + 10'h001;
    end
  end

  assign tick = (ctrl_reg.clk_sel != CLK_STOP) &&
                (pre_cnt_reg == pre_last);

  // mode decode: only the mode field shapes counting, never the actions
  always_comb
  begin
    is_pwm         = 1'b0;
    is_ctc         = 1'b0;
    top_from_cmp_a = 1'b0;
    top_from_ceil  = 1'b0;
    top_val        = CNT_MAX;
    width_mask     = CNT_MAX;
    case (ctrl_reg.mode)
      MODE_CTC_CMP:
      begin
        is_ctc         = 1'b1;
        top_from_cmp_a = 1'b1;
        top_val        = cmp_reg[CH_A];
      end
      MODE_CTC_CEIL:
      begin
        is_ctc        = 1'b1;
        top_from_ceil = 1'b1;
        top_val       = ceil_reg;
      end
      MODE_FPWM_8:
      begin
        is_pwm     = 1'b1;
        top_val    = TOP_8BIT;
        width_mask = TOP_8BIT;
      end
      MODE_FPWM_9:
      begin
        is_pwm     = 1'b1;
        top_val    = TOP_9BIT;
        width_mask = TOP_9BIT;
      end
      MODE_FPWM_10:
      begin
        is_pwm     = 1'b1;
        top_val    = TOP_10BIT;
        width_mask = TOP_10BIT;
      end
      MODE_FPWM_CEIL:
      begin
        is_pwm        = 1'b1;
        top_from_ceil = 1'b1;
        top_val       = ceil_reg;
      end
      MODE_FPWM_CMP:
      begin
        is_pwm         = 1'b1;
        top_from_cmp_a = 1'b1;
        top_val        = cmp_reg[CH_A];
      end
      default:
      begin
        top_val = CNT_MAX;
      end
    endcase
  end

  // a ceiling below the count is simply never equal, so the count runs on
  assign top_hit  = (count_reg == top_val) && !block_reg;
  assign wrap_max = (count_reg == CNT_MAX);

  // next count: clear at ceiling in clearing modes, else increment/wrap
  always_comb
  begin
    if ((is_ctc || is_pwm) && top_hit)
    begin
      count_next = CNT_BOTTOM;
    end
    else
    begin
      count_next = count_reg + CNT_ONE;
    end
  end

  // counter; a software write wins over a tick in the same clock
  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      count_reg <= CNT_BOTTOM;
    end
    else if (wr && adr == OFS_COUNT)
    begin
      count_reg <= merge16(count_reg, wb_dat_in, wb_sel_in);
    end
    else if (tick)
    begin
      count_reg <= count_next;
    end
  end

  // a count write masks matches on the following tick
  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      block_reg <= 1'b0;
    end
    else if (wr && adr == OFS_COUNT)
    begin
      block_reg <= 1'b1;
    end
    else if (tick)
    begin
      block_reg <= 1'b0;
    end
  end

  // ceiling register takes effect at once, no buffer
  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ceil_reg <= CNT_BOTTOM;
    end
    else if (wr && adr == OFS_CEIL)
    begin
      ceil_reg <= merge16(ceil_reg, wb_dat_in, wb_sel_in);
    end
  end

  // control register
  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ctrl_reg <= CTRL_RESET;
    end
    else if (wr && adr == OFS_CTRL)
    begin
      ctrl_reg <= CTRL_W'(merge16(16'(ctrl_reg), wb_dat_in, wb_sel_in));
    end
  end

  // per-channel compare, buffer and waveform logic
  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_ch
    tw_action_e act;

    assign act = tw_action_e'((ch == CH_A) ? ctrl_reg.act_a
                                           : ctrl_reg.act_b);
    assign cmp_wr[ch] = wr &&
                        adr == ((ch == CH_A) ? OFS_CMP_A : OFS_CMP_B);
    assign cmp_wdata[ch] = merge16(buf_reg[ch], wb_dat_in, wb_sel_in) &
                           width_mask;
    assign match[ch] = (count_reg == cmp_reg[ch]) && !block_reg;

    // software always lands in the buffer
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
      if (reset_in)
      begin
        buf_reg[ch] <= CNT_BOTTOM;
      end
      else if (cmp_wr[ch])
      begin
        buf_reg[ch] <= cmp_wdata[ch];
      end
    end

    // active compare: direct outside pwm, copied at ceiling inside pwm
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
      if (reset_in)
      begin
        cmp_reg[ch] <= CNT_BOTTOM;
      end
      else if (cmp_wr[ch] && !is_pwm)
      begin
        cmp_reg[ch] <= cmp_wdata[ch];
      end
      else if (tick && is_pwm && top_hit)
      begin
        cmp_reg[ch] <= buf_reg[ch];
      end
    end

    // wave register; the wrap action wins so compare at ceiling is level
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
      if (reset_in)
      begin
        wave_reg[ch] <= 1'b0;
      end
      else if (tick && is_pwm)
      begin
        case (act)
          ACT_TOGGLE:
          begin
            if (ch == CH_A && ctrl_reg.mode == MODE_FPWM_CMP && match[ch])
            begin
              wave_reg[ch] <= ~wave_reg[ch];
            end
          end
          ACT_CLEAR:
          begin
            if (top_hit)
            begin
              wave_reg[ch] <= 1'b1;
            end
            else if (match[ch])
            begin
              wave_reg[ch] <= 1'b0;
            end
          end
          ACT_SET:
          begin
            if (top_hit)
            begin
              wave_reg[ch] <= 1'b0;
            end
            else if (match[ch])
            begin
              wave_reg[ch] <= 1'b1;
            end
          end
          default:
          begin
            wave_reg[ch] <= wave_reg[ch];
          end
        endcase
      end
      else if (tick && match[ch])
      begin
        case (act)
          ACT_TOGGLE: wave_reg[ch] <= ~wave_reg[ch];
          ACT_CLEAR:  wave_reg[ch] <= 1'b0;
          ACT_SET:    wave_reg[ch] <= 1'b1;
          default:    wave_reg[ch] <= wave_reg[ch];
        endcase
      end
    end
  end

  // flag events, all on ticks
  always_comb
  begin
    flag_set = '0;
    flag_clr = '0;
    if (tick)
    begin
      flag_set[FLAG_OVF]   = is_pwm ? top_hit : wrap_max;
      flag_set[FLAG_CMP_A] = match[CH_A];
      flag_set[FLAG_CMP_B] = match[CH_B];
      flag_set[FLAG_CAP]   = top_hit && top_from_ceil;
    end
    if (wr && adr == OFS_FLAGS && wb_sel_in[0])
    begin
      flag_clr = wb_dat_in[FLAG_W-1:0];
    end
  end

  // sticky flags: write one to clear, a same-clock event wins
  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      flag_reg <= '0;
    end
    else
    begin
      flag_reg <= (flag_reg & ~flag_clr) | flag_set;
    end
  end

  // pin drive: wave shown only with direction set to output
  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pin_reg  <= '0;
      oe_n_reg <= '1;
    end
    else
    begin
      pin_reg  <= wave_reg & ctrl_reg.pin_dir;
      oe_n_reg <= ~ctrl_reg.pin_dir;
    end
  end

  // read mux; reads return the buffered compare value software wrote
  always_comb
  begin
    rd_data = '0;
    if (adr == OFS_CTRL)
    begin
      rd_data = DAT_W'(ctrl_reg);
    end
    else if (adr == OFS_COUNT)
    begin
      rd_data = DAT_W'(count_reg);
    end
    else if (adr == OFS_CMP_A)
    begin
      rd_data = DAT_W'(buf_reg[CH_A]);
    end
    else if (adr == OFS_CMP_B)
    begin
      rd_data = DAT_W'(buf_reg[CH_B]);
    end
    else if (adr == OFS_CEIL)
    begin
      rd_data = DAT_W'(ceil_reg);
    end
    else if (adr == OFS_FLAGS)
    begin
      rd_data = DAT_W'(flag_reg);
    end
    else if (adr == OFS_STATUS)
    begin
      rd_data = DAT_W'(wave_reg);
    end
  end

  // bus answer: ack one clock after request, dropped the next clock
  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end
    else
    begin
      ack_reg <= req;
      if (req)
      begin
        dat_reg <= rd_data;
      end
    end
  end

  assign wb_ack_out        = ack_reg;
  assign wb_dat_out        = dat_reg;
  assign wave_pin_out      = pin_reg;
  assign wave_pin_oe_n_out = oe_n_reg;

endmodule

`default_nettype wire

// *** verification/tw_timer16_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none

// port-level checker: bus handshake and pin gating of the timer
module tw_timer16_chk
  import tw_pkg::*;
(
  input wire logic              ref_clk_in,
  input wire logic              reset_in,
  input wire logic              wb_cyc_in,
  input wire logic              wb_stb_in,
  input wire logic              wb_we_in,
  input wire logic [ADR_W-1:0]  wb_adr_in,
  input wire logic [DAT_W-1:0]  wb_dat_out,
  input wire logic              wb_ack_out,
  input wire logic [NUM_CH-1:0] wave_pin_out,
  input wire logic [NUM_CH-1:0] wave_pin_oe_n_out
);
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  // a taken request is answered on the next edge, for exactly one cycle
  AST_ACK_NEXT:
    assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack late");
  AST_ACK_PULSE:
    assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held");
  AST_ACK_NEEDS_REQ:
    assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
    else $error("ack without request");
  // read data only moves together with a new answer
  AST_DAT_HOLD:
    assert property (!$rose(wb_ack_out) |-> $stable(wb_dat_out))
    else $error("read data moved");
  AST_UNMAPPED_ZERO:
    assert property ($rose(wb_ack_out) && !$past(wb_we_in)
                     && $past(wb_adr_in) >= 8'h1C |-> wb_dat_out == 32'h0)
    else $error("unmapped read not zero");
  AST_UPPER_ZERO:
    assert property (wb_ack_out |-> wb_dat_out[31:16] == 16'h0)
    else $error("upper read lanes set");
  // a pin set as input never shows the wave
  AST_PIN_A_GATED:
    assert property (wave_pin_oe_n_out[0] |-> !wave_pin_out[0])
    else $error("pin a driven while input");
  AST_PIN_B_GATED:
    assert property (wave_pin_oe_n_out[1] |-> !wave_pin_out[1])
    else $error("pin b driven while input");
  // direction moves only right after a bus write
  AST_OE_BY_WRITE:
    assert property ($changed(wave_pin_oe_n_out) |-> wb_ack_out
                     || $past(wb_ack_out) || $past(wb_ack_out, 2))
    else $error("direction changed alone");
endmodule

bind tw_timer16 tw_timer16_chk i_tw_timer16_chk (
  .ref_clk_in        (ref_clk_in),
  .reset_in          (reset_in),
  .wb_cyc_in         (wb_cyc_in),
  .wb_stb_in         (wb_stb_in),
  .wb_we_in          (wb_we_in),
  .wb_adr_in         (wb_adr_in),
  .wb_dat_out        (wb_dat_out),
  .wb_ack_out        (wb_ack_out),
  .wave_pin_out      (wave_pin_out),
  .wave_pin_oe_n_out (wave_pin_oe_n_out)
);

`default_nettype wire

// *** verification/tw_load.sv ***
`timescale 1ns/10ps
`default_nettype none

// pin load with pull-down: counts high cycles and rising edges
module tw_load
(
  input  wire logic        clk_in,
  input  wire logic        pin_in,
  input  wire logic        oe_n_in,
  input  wire logic        clr_in,
  output var  logic [19:0] high_out,
  output var  logic [15:0] rise_out
);
  logic lvl;
  logic lvl_reg;

  // a released pin is pulled low, never left at its last value
  assign lvl = !oe_n_in && pin_in;

  // clear starts a window; whole periods give phase-free counts
  always_ff @(posedge clk_in)
  begin
    lvl_reg <= lvl;
    if (clr_in)
    begin
      high_out <= 20'h0;
      rise_out <= 16'h0;
    end
    else
    begin
      high_out <= high_out + 20'(lvl);
      rise_out <= rise_out + 16'(lvl && !lvl_reg);
    end
  end
endmodule

`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none

module testbench
  import tw_pkg::*;
;
  logic              clk, rst, cyc, stb, we, ack, clr;
  logic [ADR_W-1:0]  adr;
  logic [3:0]        sel;
  logic [DAT_W-1:0]  wdat, rdat, v;
  logic [NUM_CH-1:0] pin, oe_n;
  logic [19:0]       hi [2];
  logic [15:0]       rise [2];
  logic [31:0]       exp_q [$];
  logic [31:0]       msk_q [$];
  int                err_total, samples_checked, seed, top, m, n;
  int                pa [5] = '{2, 2, 2, 3, 3};
  int                pc [5] = '{0, 3, 9, 3, 9};
  int                ph [5] = '{1, 4, 10, 6, 0};
  int                pr [5] = '{4, 4, 0, 4, 0};

  tw_timer16 i_tw_timer16 (.ref_clk_in(clk), .reset_in(rst),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .wave_pin_out(pin), .wave_pin_oe_n_out(oe_n));
  tw_load i_tw_load_a (.clk_in(clk), .pin_in(pin[0]), .oe_n_in(oe_n[0]),
    .clr_in(clr), .high_out(hi[0]), .rise_out(rise[0]));
  tw_load i_tw_load_b (.clk_in(clk), .pin_in(pin[1]), .oe_n_in(oe_n[1]),
    .clr_in(clr), .high_out(hi[1]), .rise_out(rise[1]));

  // 20 MHz reference clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic fail(input string s);
    err_total++;
    $display("ERROR %0t %s", $time, s);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one classic bus cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wdat <= d;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 16);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1)
    begin
      fail("bus timeout");
      close_out();
    end
  endtask

  // reads note the masked expectation before the request goes out
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] k);
    exp_q.push_back(e & k);
    msk_q.push_back(k);
    bus(1'b0, a, 32'h0);
  endtask

  // measure one pin over a window of whole periods
  task automatic win(input int ch, input int c, input int h, input int r);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (c) @(posedge clk);
    #1;
    samples_checked++;
    if (hi[ch] !== 20'(h) || rise[ch] !== 16'(r))
      fail("pin waveform");
  endtask

  function automatic logic [31:0] ctl(input logic [3:0] md,
    input logic [1:0] aa, input logic [1:0] ab, input logic [2:0] cs);
    tw_ctrl_s c;
    c = '{pin_dir: 2'h3, clk_sel: cs, act_b: ab, act_a: aa, mode: md};
    return {19'h0, c};
  endfunction

  // takes the oldest note off the queue whenever a read is answered
  always @(posedge clk)
  begin
    if (ack === 1'b1 && we === 1'b0 && cyc === 1'b1)
    begin
      samples_checked++;
      if (exp_q.size() == 0)
        fail("unexpected read");
      else if ((rdat & msk_q[0]) !== exp_q[0])
        fail("read data mismatch");
      if (exp_q.size() != 0)
      begin
        exp_q.delete(0);
        msk_q.delete(0);
      end
    end
  end

  // cuts a hung run short
  initial
  begin
    repeat (95000) @(posedge clk);
    fail("run timeout");
    close_out();
  end

  // main sequence
  initial
  begin
    seed = 85251;
    {rst, cyc, stb, we, clr, adr, wdat} = {1'b1, 4'h0, 8'h00, 32'h0};
    sel = 4'hF;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_CTRL, 32'h0, 32'hFFFFFFFF);
    for (int i = 0; i < 4; i++)
    begin
      v = $random(seed);
      bus(1'b1, OFS_CEIL, v);
      rd(OFS_CEIL, {16'h0, v[15:0]}, 32'hFFFFFFFF);
    end
    bus(1'b1, 8'h1C, 32'hFFFF);
    rd(8'h1C, 32'h0, 32'hFFFFFFFF);
    $display("test registers done");
    bus(1'b1, OFS_COUNT, 32'hFFF0);
    bus(1'b1, OFS_FLAGS, 32'hF);
    bus(1'b1, OFS_CTRL, ctl(MODE_NORMAL, ACT_NONE, ACT_NONE, CLK_DIV1));
    repeat (40) @(posedge clk);
    bus(1'b1, OFS_CTRL, ctl(MODE_NORMAL, ACT_NONE, ACT_NONE, CLK_STOP));
    rd(OFS_FLAGS, 32'h1, 32'h1);
    rd(OFS_COUNT, 32'h0, 32'hFF00);
    $display("test plain count done");
    for (int i = 0; i < 2; i++)
    begin
      bus(1'b1, OFS_CEIL, 32'h4);
      bus(1'b1, OFS_CMP_A, i ? 32'h2 : 32'h4);
      bus(1'b1, OFS_COUNT, 32'h0);
      bus(1'b1, OFS_CTRL, ctl(i ? MODE_CTC_CEIL : MODE_CTC_CMP,
                              ACT_TOGGLE, ACT_NONE, CLK_DIV1));
      bus(1'b1, OFS_FLAGS, 32'hF);
      win(0, 40, 20, 4);
      win(1, 40, 0, 0);
      rd(OFS_FLAGS, i ? 32'h8 : 32'h2, i ? 32'h9 : 32'h3);
    end
    // direction bits cleared: the toggling wave must not reach the pin
    bus(1'b1, OFS_CTRL, ctl(MODE_CTC_CEIL, ACT_TOGGLE, ACT_NONE, CLK_DIV1)
                        & 32'h7FF);
    win(0, 40, 0, 0);
    bus(1'b1, OFS_CMP_A, 32'h3E8);
    bus(1'b1, OFS_CTRL, ctl(MODE_CTC_CMP, ACT_NONE, ACT_NONE, CLK_DIV1));
    repeat (100) @(posedge clk);
    bus(1'b1, OFS_CMP_A, 32'hA);
    bus(1'b1, OFS_FLAGS, 32'hF);
    rd(OFS_FLAGS, 32'h0, 32'h1);
    repeat (65600) @(posedge clk);
    rd(OFS_FLAGS, 32'h1, 32'h1);
    $display("test clear on match done");
    bus(1'b1, OFS_CEIL, 32'h9);
    bus(1'b1, OFS_COUNT, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b1, OFS_CTRL, ctl(MODE_FPWM_CEIL, ACT_NONE, 2'(pa[i]), CLK_DIV1));
      bus(1'b1, OFS_CMP_B, 32'(pc[i]));
      bus(1'b1, OFS_FLAGS, 32'hF);
      repeat (30) @(posedge clk);
      win(1, 40, 4 * ph[i], pr[i]);
      rd(OFS_FLAGS, 32'h9, 32'h9);
    end
    // count above the capture ceiling runs on to max, then wraps back under
    bus(1'b1, OFS_COUNT, 32'hFFF0);
    rd(OFS_COUNT, 32'hFFF0, 32'hFFF0);
    repeat (30) @(posedge clk);
    rd(OFS_COUNT, 32'h0, 32'hFFF0);
    for (int i = 0; i < 3; i++)
    begin
      top = (256 << i) - 1;
      m = 'hAB40 & top;
      bus(1'b1, OFS_CTRL, ctl(4'(5 + i), ACT_NONE, ACT_CLEAR, CLK_DIV1));
      bus(1'b1, OFS_CMP_B, 32'hAB40);
      rd(OFS_CMP_B, 32'(m), 32'hFFFFFFFF);
      repeat (top + 20) @(posedge clk);
      win(1, 2 * (top + 1), 2 * (m + 1), 2);
    end
    bus(1'b1, OFS_COUNT, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      n = 1 << (3 * i);
      bus(1'b1, OFS_CTRL, ctl(MODE_FPWM_CMP, ACT_TOGGLE, ACT_NONE, 3'(i + 1)));
      bus(1'b1, OFS_CMP_A, 32'h9);
      bus(1'b1, OFS_FLAGS, 32'hF);
      repeat (n * 40) @(posedge clk);
      win(0, n * 40, n * 20, 2);
      rd(OFS_FLAGS, 32'h3, 32'h3);
    end
    $display("test fast pwm done");
    close_out();
  end
endmodule

`default_nettype wire
